// >>> rtl/icp_pkg.sv
// shared constants, command tree and types of the instrument command parser
package icp_pkg;

  // longest command word held, in characters
  localparam int ICP_WMAX = 12;
  // command tree entries; entry 0 is the root and holds no word
  localparam int ICP_N = 10;
  // default depth of the response output queue
  localparam int ICP_QDEPTH = 64;
  // length of a common command mnemonic after the asterisk
  localparam int ICP_CLEN = 3;
  // shortest word that has a separate short form, minus one
  localparam int ICP_SHORT_MIN = 4;

  // characters with a meaning to the parser
  localparam logic [7:0] ICP_CH_LF = 8'h0A;
  localparam logic [7:0] ICP_CH_SPACE = 8'h20;
  localparam logic [7:0] ICP_CH_STAR = 8'h2A;
  localparam logic [7:0] ICP_CH_COMMA = 8'h2C;
  localparam logic [7:0] ICP_CH_COLON = 8'h3A;
  localparam logic [7:0] ICP_CH_SEMI = 8'h3B;
  localparam logic [7:0] ICP_CH_QUERY = 8'h3F;

  // flag bit positions of a tree entry
  localparam int ICP_F_OPT = 0;
  localparam int ICP_F_CMD = 1;
  localparam int ICP_F_QRY = 2;

  // long form of each word, upper case, first letter in the highest used byte
  localparam logic [8*ICP_WMAX-1:0] ICP_NAME [ICP_N] = '{
    96'h0, 96'("STATUS"), 96'("OPERATION"), 96'("ENABLE"), 96'("PRESET"),
    96'("SENSE"), 96'("FUNCTION"), 96'("SYSTEM"), 96'("ERROR"), 96'("OUTPUT")};
  // long form length of each word
  localparam logic [3:0] ICP_LEN [ICP_N] = '{
    4'h0, 4'h6, 4'h9, 4'h6, 4'h6, 4'h5, 4'h8, 4'h6, 4'h5, 4'h6};
  // parent entry of each word, 0 for root words
  localparam logic [3:0] ICP_PARENT [ICP_N] = '{
    4'h0, 4'h0, 4'h1, 4'h2, 4'h1, 4'h0, 4'h5, 4'h0, 4'h7, 4'h0};
  // {query allowed, command, optional}
  localparam logic [2:0] ICP_FLAGS [ICP_N] = '{
    3'h0, 3'h0, 3'h0, 3'h6, 3'h2, 3'h1, 3'h6, 3'h0, 3'h4, 3'h6};
  // mandatory numeric suffix character, zero when none
  localparam logic [7:0] ICP_SUFFIX [ICP_N] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h31};

  // error causes reported to status logic
  typedef enum logic [2:0] {
    ICP_ERR_NONE, ICP_ERR_HEADER, ICP_ERR_QUERY, ICP_ERR_COMMON,
    ICP_ERR_LENGTH, ICP_ERR_PATH, ICP_ERR_CHAR
  } icp_err_e;

  // parser states
  typedef enum logic [2:0] {
    ICP_ST_START, ICP_ST_WORD, ICP_ST_COMMON, ICP_ST_PARAM,
    ICP_ST_DISCARD, ICP_ST_WAITQ
  } icp_state_e;

endpackage

// >>> rtl/icp_fifo2.sv
// two-entry valid/ready buffer in front of the talker port
`timescale 1ns/1ps
`default_nettype none
module icp_fifo2 #(
  parameter int W = 9
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  if (W < 1) begin : g_chk
    $error("icp_fifo2 needs W of at least 1");
  end

  logic [W-1:0] slot1; // second entry, behind out_data
  logic [1:0] cnt; // entries held
  logic push;
  logic pop;

  assign in_ready = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // occupancy
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 2'h0;
    end else if (push && !pop) begin
      cnt <= cnt + 2'h1;
    end else if (pop && !push) begin
      cnt <= cnt - 2'h1;
    end
  end

  // data slots; head always in out_data so the output is a flop
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      out_data <= '0;
      slot1 <= '0;
    end else if (push && pop) begin
      if (cnt == 2'h1) begin
        out_data <= in_data;
      end else begin
        out_data <= slot1;
        slot1 <= in_data;
      end
    end else if (pop) begin
      out_data <= slot1;
    end else if (push) begin
      if (cnt == 2'h0) begin
        out_data <= in_data;
      end else begin
        slot1 <= in_data;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/icp_word_match.sv
// compares a received word against one entry in long or short form
`timescale 1ns/1ps
`default_nettype none
module icp_word_match (
  // received word, last character in the lowest byte
  input wire logic [8*icp_pkg::ICP_WMAX-1:0] word,
  input wire logic [3:0] wlen,
  // table entry
  input wire logic [8*icp_pkg::ICP_WMAX-1:0] name,
  input wire logic [3:0] len,
  input wire logic [7:0] suffix,
  // result
  output logic match
);
  logic [3:0] short_len; // short form length of the entry
  logic [3:0] blen; // word length without its suffix
  logic [8*icp_pkg::ICP_WMAX-1:0] base; // word without its suffix
  logic same; // leading characters agree
  logic [7:0] fourth; // fourth letter of the long form

  // short form and prefix compare
  always_comb begin
    fourth = name[8*(len-4'h4)+:8];
    if (len <= 4'(icp_pkg::ICP_SHORT_MIN)) begin
      short_len = len;
    end else if (fourth == "A" || fourth == "E" || fourth == "I" ||
                 fourth == "O" || fourth == "U" || fourth == "Y") begin
      short_len = 4'h3;
    end else begin
      short_len = 4'h4;
    end
    if (suffix != 8'h00) begin
      blen = wlen - 4'h1;
      base = word >> 8;
    end else begin
      blen = wlen;
      base = word;
    end
    same = 1'b1;
    for (int i = 0; i < icp_pkg::ICP_WMAX; i++) begin
      if (4'(i) < blen && base[8*(blen-4'(i)-4'h1)+:8] != name[8*(len-4'(i)-4'h1)+:8]) begin
        same = 1'b0;
      end
    end
    match = same && (blen == len || blen == short_len) &&
            (suffix == 8'h00 || (wlen != 4'h0 && word[7:0] == suffix));
  end
endmodule
`default_nettype wire

// >>> rtl/icp_parser.sv
// program message parser, path pointer, executor strobes and response queue
`timescale 1ns/1ps
`default_nettype none
module icp_parser #(
  parameter int QDEPTH = icp_pkg::ICP_QDEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // program message bytes from the bus
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_eoi,
  output logic rx_ready,
  // decoded tree commands
  output logic cmd_valid,
  output logic [3:0] cmd_node,
  output logic cmd_query,
  // parameter characters of the command about to issue
  output logic par_valid,
  output logic [7:0] par_data,
  // decoded common commands
  output logic common_valid,
  output logic [8*icp_pkg::ICP_CLEN-1:0] common_name,
  output logic common_query,
  // query answer beats from the executor
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic resp_sep,
  input wire logic resp_end,
  output logic resp_ready,
  // talker side
  input wire logic talk_addressed,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_eoi,
  input wire logic tx_ready,
  // error report
  output logic err_pulse,
  output icp_pkg::icp_err_e err_code
);
  localparam int QW = $clog2(QDEPTH);

  if (QDEPTH < 4 || (QDEPTH & (QDEPTH - 1)) != 0) begin : g_chk
    $error("icp_parser needs QDEPTH a power of two of at least 4");
  end

  // case folding of a received character
  function automatic logic [7:0] fold(input logic [7:0] c);
    fold = (c >= "a" && c <= "z") ? c - 8'h20 : c;
  endfunction

  // letters and digits form words
  function automatic logic is_name(input logic [7:0] c);
    is_name = (c >= "A" && c <= "Z") || (c >= "0" && c <= "9");
  endfunction

  icp_pkg::icp_state_e state; // parser state
  logic [3:0] level; // path pointer, 0 is root
  logic [8*icp_pkg::ICP_WMAX-1:0] wbuf; // word being collected
  logic [3:0] wlen; // characters in wbuf
  logic [1:0] clen; // letters of a common mnemonic
  logic pend_common; // pending command is common
  logic [3:0] pend_node; // pending tree entry
  logic pend_query; // pending command is a query
  logic had_query; // message already queued a response
  logic term_pend; // terminator seen while waiting on a query

  // byte decode
  logic take; // byte accepted this cycle
  logic [7:0] ch; // folded character
  logic term; // byte ends the message
  logic cat; // eoi byte completes the word
  logic [8*icp_pkg::ICP_WMAX-1:0] rword; // word used for resolution
  logic [3:0] rlen;

  // output queue
  logic [8:0] qmem [QDEPTH]; // {eoi, character}
  logic [QW-1:0] wr_ptr;
  logic [QW-1:0] rd_ptr;
  logic [QW:0] qcnt;
  logic [QW:0] msgs; // complete messages held
  logic q_push;
  logic [8:0] q_wdata;
  logic q_room; // two free places, room for a separator and a terminator
  logic q_pop;
  logic buf_ready;

  assign ch = fold(rx_data);
  assign take = rx_valid && rx_ready;
  // LF or EOI ends a message
  assign term = (ch == icp_pkg::ICP_CH_LF) || rx_eoi;
  assign cat = rx_eoi && is_name(ch) && state == icp_pkg::ICP_ST_WORD;
  assign rword = cat ? {wbuf[8*icp_pkg::ICP_WMAX-9:0], ch} : wbuf;
  assign rlen = cat ? wlen + 4'h1 : wlen;
  assign q_room = (qcnt < (QW+1)'(QDEPTH - 1));
  // stall input while a query answer is collected or the queue is tight
  assign rx_ready = (state != icp_pkg::ICP_ST_WAITQ) && q_room;
  assign resp_ready = (state == icp_pkg::ICP_ST_WAITQ) && q_room;

  // word match against every entry in the tree
  logic [icp_pkg::ICP_N-1:0] raw;
  logic [icp_pkg::ICP_N-1:0] hit;
  assign raw[0] = 1'b0;
  assign hit[0] = 1'b0;
  for (genvar e = 1; e < icp_pkg::ICP_N; e++) begin : g_match
    icp_word_match u_match (
      .word(rword),
      .wlen(rlen),
      .name(icp_pkg::ICP_NAME[e]),
      .len(icp_pkg::ICP_LEN[e]),
      .suffix(icp_pkg::ICP_SUFFIX[e]),
      .match(raw[e])
    );
    // children of optional roots count as roots
    // only entries below the pointer resolve
    assign hit[e] = raw[e] && (icp_pkg::ICP_PARENT[e] == level ||
      (level == 4'h0 && icp_pkg::ICP_FLAGS[icp_pkg::ICP_PARENT[e]][icp_pkg::ICP_F_OPT]));
  end

  // lowest matching entry
  function automatic logic [3:0] first_hit(input logic [icp_pkg::ICP_N-1:0] h);
    first_hit = 4'h0;
    for (int i = icp_pkg::ICP_N - 1; i > 0; i--) begin
      if (h[i]) begin
        first_hit = 4'(i);
      end
    end
  endfunction

  logic [3:0] node;
  logic [2:0] nflags;
  assign node = first_hit(hit);
  assign nflags = icp_pkg::ICP_FLAGS[node];

  // parser state machine and strobes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= icp_pkg::ICP_ST_START;
      level <= 4'h0;
      wbuf <= '0;
      wlen <= 4'h0;
      clen <= 2'h0;
      pend_common <= 1'b0;
      pend_node <= 4'h0;
      pend_query <= 1'b0;
      had_query <= 1'b0;
      term_pend <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_node <= 4'h0;
      cmd_query <= 1'b0;
      par_valid <= 1'b0;
      par_data <= 8'h00;
      common_valid <= 1'b0;
      common_name <= '0;
      common_query <= 1'b0;
      err_pulse <= 1'b0;
      err_code <= icp_pkg::ICP_ERR_NONE;
      q_push <= 1'b0;
      q_wdata <= 9'h000;
    end else begin
      // one-cycle strobes fall back by default
      cmd_valid <= 1'b0;
      par_valid <= 1'b0;
      common_valid <= 1'b0;
      err_pulse <= 1'b0;
      q_push <= 1'b0;
      if (state == icp_pkg::ICP_ST_WAITQ) begin
        // collect the executor's answer into the queue
        if (resp_valid && resp_ready) begin
          if (resp_end) begin
            if (term_pend) begin
              q_push <= 1'b1;
              q_wdata <= {1'b1, icp_pkg::ICP_CH_LF};
              had_query <= 1'b0;
              level <= 4'h0;
            end
            term_pend <= 1'b0;
            state <= icp_pkg::ICP_ST_START;
          end else begin
            q_push <= 1'b1;
            q_wdata <= {1'b0, resp_sep ? icp_pkg::ICP_CH_COMMA : resp_data};
          end
        end
      end else if (take) begin
        case (state)
          icp_pkg::ICP_ST_START: begin
            if (term) begin
              // empty command, close the message
              if (had_query) begin
                q_push <= 1'b1;
                q_wdata <= {1'b1, icp_pkg::ICP_CH_LF};
              end
              had_query <= 1'b0;
              level <= 4'h0;
            end else if (ch == icp_pkg::ICP_CH_SPACE) begin
              // blanks between commands are skipped
            end else if (ch == icp_pkg::ICP_CH_STAR) begin
              state <= icp_pkg::ICP_ST_COMMON;
              clen <= 2'h0;
              common_name <= '0;
              pend_query <= 1'b0;
            end else if (ch == icp_pkg::ICP_CH_COLON) begin
              level <= 4'h0;
              wlen <= 4'h0;
              state <= icp_pkg::ICP_ST_WORD;
            end else if (is_name(ch)) begin
              wbuf <= {{(8*icp_pkg::ICP_WMAX-8){1'b0}}, ch};
              wlen <= 4'h1;
              state <= icp_pkg::ICP_ST_WORD;
            end else begin
              err_pulse <= 1'b1;
              err_code <= icp_pkg::ICP_ERR_CHAR;
              state <= icp_pkg::ICP_ST_DISCARD;
            end
          end
          icp_pkg::ICP_ST_WORD: begin
            if (is_name(ch) && !rx_eoi) begin
              if (wlen == 4'(icp_pkg::ICP_WMAX)) begin
                err_pulse <= 1'b1;
                err_code <= icp_pkg::ICP_ERR_LENGTH;
                state <= icp_pkg::ICP_ST_DISCARD;
              end else begin
                wbuf <= {wbuf[8*icp_pkg::ICP_WMAX-9:0], ch};
                wlen <= wlen + 4'h1;
              end
            end else if (rlen == 4'h0 || node == 4'h0) begin
              err_pulse <= 1'b1;
              err_code <= (rlen == 4'h0) ? icp_pkg::ICP_ERR_PATH : icp_pkg::ICP_ERR_HEADER;
              state <= term ? icp_pkg::ICP_ST_START : icp_pkg::ICP_ST_DISCARD;
              if (term) begin
                if (had_query) begin
                  q_push <= 1'b1;
                  q_wdata <= {1'b1, icp_pkg::ICP_CH_LF};
                end
                had_query <= 1'b0;
                level <= 4'h0;
              end
            end else if (ch == icp_pkg::ICP_CH_COLON) begin
              level <= node;
              wlen <= 4'h0;
            end else if ((ch == icp_pkg::ICP_CH_QUERY) ? !nflags[icp_pkg::ICP_F_QRY]
                                                        : !nflags[icp_pkg::ICP_F_CMD]) begin
              err_pulse <= 1'b1;
              err_code <= icp_pkg::ICP_ERR_QUERY;
              state <= icp_pkg::ICP_ST_DISCARD;
            end else begin
              pend_common <= 1'b0;
              pend_node <= node;
              pend_query <= (ch == icp_pkg::ICP_CH_QUERY);
              state <= icp_pkg::ICP_ST_PARAM;
              // separator or terminator issues at once
              if (ch == icp_pkg::ICP_CH_SEMI || term) begin
                cmd_valid <= 1'b1;
                cmd_node <= node;
                cmd_query <= 1'b0;
                state <= icp_pkg::ICP_ST_START;
                if (term) begin
                  if (had_query) begin
                    q_push <= 1'b1;
                    q_wdata <= {1'b1, icp_pkg::ICP_CH_LF};
                  end
                  had_query <= 1'b0;
                  level <= 4'h0;
                end
              end
            end
          end
          icp_pkg::ICP_ST_COMMON: begin
            if (is_name(ch) && clen != 2'(icp_pkg::ICP_CLEN)) begin
              common_name <= {common_name[8*icp_pkg::ICP_CLEN-9:0], ch};
              clen <= clen + 2'h1;
              // eoi on the last letter ends the message
              if (rx_eoi && clen == 2'(icp_pkg::ICP_CLEN - 1)) begin
                common_valid <= 1'b1;
                common_query <= 1'b0;
                state <= icp_pkg::ICP_ST_START;
                if (had_query) begin
                  q_push <= 1'b1;
                  q_wdata <= {1'b1, icp_pkg::ICP_CH_LF};
                end
                had_query <= 1'b0;
                level <= 4'h0;
              end
            end else if (clen == 2'(icp_pkg::ICP_CLEN) &&
                         (ch == icp_pkg::ICP_CH_QUERY || ch == icp_pkg::ICP_CH_SPACE ||
                          ch == icp_pkg::ICP_CH_SEMI || term)) begin
              pend_common <= 1'b1;
              pend_query <= (ch == icp_pkg::ICP_CH_QUERY);
              state <= icp_pkg::ICP_ST_PARAM;
              if (ch == icp_pkg::ICP_CH_SEMI || term) begin
                common_valid <= 1'b1;
                common_query <= 1'b0;
                state <= icp_pkg::ICP_ST_START;
                if (term) begin
                  if (had_query) begin
                    q_push <= 1'b1;
                    q_wdata <= {1'b1, icp_pkg::ICP_CH_LF};
                  end
                  had_query <= 1'b0;
                  level <= 4'h0;
                end
              end
            end else begin
              err_pulse <= 1'b1;
              err_code <= icp_pkg::ICP_ERR_COMMON;
              state <= term ? icp_pkg::ICP_ST_START : icp_pkg::ICP_ST_DISCARD;
              if (term) begin
                // an answered query still gets its closing LF
                if (had_query) begin
                  q_push <= 1'b1;
                  q_wdata <= {1'b1, icp_pkg::ICP_CH_LF};
                end
                had_query <= 1'b0;
                level <= 4'h0;
              end
            end
          end
          icp_pkg::ICP_ST_PARAM: begin
            if (ch != icp_pkg::ICP_CH_SEMI && !(ch == icp_pkg::ICP_CH_LF) &&
                ch != icp_pkg::ICP_CH_SPACE) begin
              // forward parameter text unfolded
              par_valid <= 1'b1;
              par_data <= rx_data;
            end
            if (ch == icp_pkg::ICP_CH_SEMI || term) begin
              cmd_valid <= !pend_common;
              common_valid <= pend_common;
              cmd_node <= pend_node;
              cmd_query <= pend_query;
              common_query <= pend_query;
              if (pend_query) begin
                if (had_query) begin
                  q_push <= 1'b1;
                  q_wdata <= {1'b0, icp_pkg::ICP_CH_SEMI};
                end
                had_query <= 1'b1;
                term_pend <= term;
                state <= icp_pkg::ICP_ST_WAITQ;
              end else begin
                state <= icp_pkg::ICP_ST_START;
                if (term) begin
                  if (had_query) begin
                    q_push <= 1'b1;
                    q_wdata <= {1'b1, icp_pkg::ICP_CH_LF};
                  end
                  had_query <= 1'b0;
                  level <= 4'h0;
                end
              end
            end
          end
          icp_pkg::ICP_ST_DISCARD: begin
            if (term) begin
              if (had_query) begin
                q_push <= 1'b1;
                q_wdata <= {1'b1, icp_pkg::ICP_CH_LF};
              end
              had_query <= 1'b0;
              level <= 4'h0;
              state <= icp_pkg::ICP_ST_START;
            end
          end
          default: begin
            state <= icp_pkg::ICP_ST_START;
          end
        endcase
      end
    end
  end

  // drain only while addressed to talk and a whole message waits
  assign q_pop = talk_addressed && (msgs != '0) && buf_ready;

  // output queue storage
  always_ff @(posedge clk_sys) begin
    if (q_push) begin
      qmem[wr_ptr] <= q_wdata;
    end
  end

  // queue pointers and message count
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      qcnt <= '0;
      msgs <= '0;
    end else begin
      if (q_push) begin
        wr_ptr <= wr_ptr + QW'(1);
      end
      if (q_pop) begin
        rd_ptr <= rd_ptr + QW'(1);
      end
      if (q_push && !q_pop) begin
        qcnt <= qcnt + (QW+1)'(1);
      end else if (q_pop && !q_push) begin
        qcnt <= qcnt - (QW+1)'(1);
      end
      // a message counts once its closing LF is queued
      if ((q_push && q_wdata[8]) && !(q_pop && qmem[rd_ptr][8])) begin
        msgs <= msgs + (QW+1)'(1);
      end else if (!(q_push && q_wdata[8]) && (q_pop && qmem[rd_ptr][8])) begin
        msgs <= msgs - (QW+1)'(1);
      end
    end
  end

  // two-entry buffer so a stalled receiver loses no character
  icp_fifo2 #(
    .W(9)
  ) u_txbuf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(q_pop),
    .in_ready(buf_ready),
    .in_data(qmem[rd_ptr]),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data({tx_eoi, tx_data})
  );
endmodule
`default_nettype wire

// >>> verif/icp_parser_props.sv
// port checker for the command parser
`timescale 1ns/1ps
`default_nettype none
module icp_parser_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // watched ports
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic cmd_valid,
  input wire logic common_valid,
  input wire logic resp_ready,
  input wire logic talk_addressed,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_eoi,
  input wire logic tx_ready,
  input wire logic err_pulse,
  input wire icp_pkg::icp_err_e err_code
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // talker word held back by the host
  sequence s_stall; tx_valid && !tx_ready; endsequence
  // three cycles not addressed, so nothing in flight
  sequence s_mute; !talk_addressed [*3]; endsequence
  sequence s_err; err_pulse; endsequence
  property p_hold; s_stall |=> tx_valid && $stable(tx_data) && $stable(tx_eoi); endproperty
  a_hold: assert property (p_hold) else $error("tx word moved");
  property p_eoi; tx_valid && tx_eoi |-> tx_data == icp_pkg::ICP_CH_LF; endproperty
  a_eoi: assert property (p_eoi) else $error("eoi off lf");
  property p_talk; s_mute |=> !$rose(tx_valid); endproperty
  a_talk: assert property (p_talk) else $error("tx unaddressed");
  property p_cmd; cmd_valid |-> $past(rx_valid && rx_ready); endproperty
  a_cmd: assert property (p_cmd) else $error("cmd without byte");
  property p_com; common_valid |=> !common_valid; endproperty
  a_com: assert property (p_com) else $error("common strobe long");
  property p_err; s_err |-> err_code != icp_pkg::ICP_ERR_NONE && $past(rx_valid && rx_ready)
    ##1 (!err_pulse || $past(rx_valid && rx_ready)); endproperty
  a_err: assert property (p_err) else $error("bad error pulse");
  property p_stop; s_err |-> !cmd_valid ##1 !cmd_valid && !common_valid; endproperty
  a_stop: assert property (p_stop) else $error("issue after error");
  property p_wait; resp_ready && $past(resp_ready) |->
    !rx_ready && !cmd_valid && !common_valid; endproperty
  a_wait: assert property (p_wait) else $error("rx open in query");
endmodule
bind icp_parser icp_parser_props u_props (.clk_sys(clk_sys), .rst_b(rst_b), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .cmd_valid(cmd_valid), .common_valid(common_valid),
  .resp_ready(resp_ready), .talk_addressed(talk_addressed), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_ready(tx_ready), .err_pulse(err_pulse),
  .err_code(err_code));
`default_nettype wire

// >>> verif/icp_host_model.sv
// host computer: sends program messages, reads responses
`timescale 1ns/1ps
`default_nettype none
module icp_host_model (
  // clock
  input wire logic clk_sys,
  // program message side
  output logic rx_valid = 1'b0,
  output logic [7:0] rx_data = 8'h00,
  output logic rx_eoi = 1'b0,
  input wire logic rx_ready,
  // talker side
  output logic talk_addressed = 1'b0,
  output logic tx_ready = 1'b0,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_eoi
);
  int tmo = 0;
  logic eoi;
  // eoi marks the last byte; an lf is sent only where the string holds one
  task automatic send(input string s);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      rx_valid <= 1'b1;
      rx_data <= s[i];
      rx_eoi <= (i == s.len() - 1);
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (rx_ready !== 1'b1 && n < 500);
      if (n >= 500) tmo++;
    end
    rx_valid <= 1'b0;
    rx_eoi <= 1'b0;
    // released line shows the inverse, not a stale byte
    rx_data <= ~rx_data;
  endtask
  // talk only after the queries, drain up to the first eoi, stall every other cycle
  task automatic get(output string r);
    r = "";
    eoi = 1'b0;
    talk_addressed <= 1'b1;
    for (int n = 0; n < 200 && !eoi; n++) begin
      @(posedge clk_sys);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        r = {r, string'(tx_data)};
        eoi = tx_eoi;
      end
      tx_ready <= !eoi && !tx_ready;
    end
    if (eoi !== 1'b1) tmo++;
    talk_addressed <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/test_icp_parser.sv
// self-checking bench for the command parser
`timescale 1ns/1ps
`default_nettype none
module test_icp_parser;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic rx_valid, rx_eoi, rx_ready, talk_addressed, tx_ready, tx_valid, tx_eoi, resp_ready;
  logic [7:0] rx_data, tx_data, par_data;
  logic [7:0] resp_data = 8'h30;
  logic cmd_valid, common_valid, err_pulse, cmd_query, common_query, par_valid, lq, lcq;
  logic [1:0] beat = 2'h0;
  logic [3:0] cmd_node, lnode;
  logic [23:0] common_name, lcom;
  logic [15:0] lpar;
  icp_pkg::icp_err_e err_code, lerr;
  int fails = 0, checked = 0, ncmd = 0, nerr = 0;
  string r;
  always #2 clk_sys = ~clk_sys;
  icp_parser DUT (.clk_sys(clk_sys), .rst_b(rst_b), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_eoi(rx_eoi), .rx_ready(rx_ready), .cmd_valid(cmd_valid), .cmd_node(cmd_node),
    .cmd_query(cmd_query), .par_valid(par_valid), .par_data(par_data),
    .common_valid(common_valid), .common_name(common_name), .common_query(common_query),
    .resp_valid(1'b1), .resp_data(resp_data), .resp_sep(beat == 2'h1),
    .resp_end(beat == 2'h3), .resp_ready(resp_ready),
    .talk_addressed(talk_addressed), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_eoi(tx_eoi), .tx_ready(tx_ready), .err_pulse(err_pulse), .err_code(err_code));
  icp_host_model host (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_eoi(rx_eoi), .rx_ready(rx_ready), .talk_addressed(talk_addressed),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_eoi(tx_eoi));
  // executor answers digit, comma, digit, end; digits count up per query
  always @(posedge clk_sys) begin
    if (resp_ready === 1'b1) begin
      beat <= beat + 2'h1;
      if (beat == 2'h3) resp_data <= resp_data + 8'h01;
    end
    if (cmd_valid === 1'b1) begin
      ncmd++;
      lnode = cmd_node;
      lq = cmd_query;
    end
    if (err_pulse === 1'b1) begin
      nerr++;
      lerr = err_code;
    end
    if (common_valid === 1'b1) {lcq, lcom} = {common_query, common_name};
    if (par_valid === 1'b1) lpar = {lpar[7:0], par_data};
  end
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      fails++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // one message: count of tree command issues, last entry, count of errors
  task automatic run(input string m, input int c, input logic [3:0] nd, input int e);
    ncmd = 0;
    nerr = 0;
    host.send(m);
    repeat (3) @(posedge clk_sys);
    chk(ncmd == c && nerr == e && (c == 0 || lnode === nd), m);
  endtask
  task automatic t_case();
    run("sTaT:oPeR:EnAbLe 5e\n", 1, 4'h3, 0);
    chk(lpar === "5e", "param text");
    run("*rSt\n", 0, 4'h0, 0);
    chk(lcom === "RST" && lcq === 1'b0, "common name");
    run("*oPc", 0, 4'h0, 0);
    chk(lcom === "OPC", "eoi common");
  endtask
  task automatic t_words();
    run("STATUS:OPERATION:ENABLE 1\n", 1, 4'h3, 0);
    run("stat:pres\n", 1, 4'h4, 0);
    run("stat:prese\n", 0, 4'h0, 1);
    chk(lerr === icp_pkg::ICP_ERR_HEADER, "error code");
    run("stat:pres", 1, 4'h4, 0);
    run("outp 1\n", 0, 4'h0, 1);
    run("outp1 1\n", 1, 4'h9, 0);
    run("func 1\n", 1, 4'h6, 0);
    run(":stat:pres\n", 1, 4'h4, 0);
    run("stat:pres;:oper:enab 1\n", 1, 4'h4, 1);
    run("stat:pres;bogus;stat:pres\n", 1, 4'h4, 1);
  endtask
  task automatic t_query();
    run("syst:err?;:stat:oper:enab 1;*cls;enab?\n", 3, 4'h3, 0);
    chk(lq === 1'b1 && lcom === "CLS", "query issue");
    repeat (8) @(posedge clk_sys);
    chk(tx_valid === 1'b0, "sent unaddressed");
    host.get(r);
    chk(r == "0,0;1,1\n" && host.eoi === 1'b1, r);
  endtask
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_case();
    t_words();
    t_query();
    chk(host.tmo == 0, "timeout");
    final_report();
  end
endmodule
`default_nettype wire
